// ===== verilog/qci_regs.vh
`ifndef QCI_REGS_VH
`define QCI_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define QCI_OFF_CTRL 6'h00
`define QCI_OFF_IOCTL 6'h04
`define QCI_OFF_STAT 6'h08
`define QCI_OFF_POS 6'h0C
`define QCI_OFF_IDXCNT 6'h10
`define QCI_OFF_TIMER 6'h14
`define QCI_OFF_VEL 6'h18
`define QCI_OFF_CMPHI 6'h1C
`define QCI_OFF_CMPLO 6'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define QCI_CTRL_WMASK 16'hBF7F
`define QCI_CTRL_RST 16'h0000
`define QCI_CTRL_EN 15
`define QCI_CTRL_IDLE 13
`define QCI_CTRL_PIM_HI 12
`define QCI_CTRL_PIM_LO 10
`define QCI_CTRL_IMVB 9
`define QCI_CTRL_IMVA 8
`define QCI_CTRL_DIV_HI 6
`define QCI_CTRL_DIV_LO 4
`define QCI_CTRL_DINV 3
`define QCI_CTRL_GATE 2
`define QCI_CTRL_CCM_HI 1
`define QCI_CTRL_CCM_LO 0

// ----------------------------------------------------------------
// io control fields (low six bits writable, status above)
// ----------------------------------------------------------------
`define QCI_IO_SWAP 0
`define QCI_IO_AINV 1
`define QCI_IO_BINV 2
`define QCI_IO_IINV 3
`define QCI_IO_HINV 4
`define QCI_IO_CAPEN 5
`define QCI_IO_WBITS 6
`define QCI_IO_RST 6'h00

// status flags, write one to clear
`define QCI_ST_IDX 0
`define QCI_ST_HOME 1
`define QCI_ST_INIT 2

// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define QCI_PIM_NONE 3'h0
`define QCI_PIM_CLR 3'h1
`define QCI_PIM_NEXT 3'h2
`define QCI_PIM_HOME1 3'h3
`define QCI_PIM_HOME2 3'h4
`define QCI_PIM_CMP 3'h5
`define QCI_PIM_MOD 3'h6
`define QCI_CCM_QUAD 2'h0
`define QCI_CCM_EXTDIR 2'h1
`define QCI_CCM_EXTCLK 2'h2
`define QCI_CCM_TIMER 2'h3

`define QCI_DIV_W 7
`define QCI_VEL_W 16
`define QCI_POS_W 32

`endif

// ===== verilog/qci_sync.v
`timescale 1ns/10ps
// two-stage synchroniser, one per bit
module qci_sync #(
    parameter W = 4
) (
    input wire clk,        // system clock
    input wire arst_n,     // async reset, active low
    input wire [W-1:0] d,  // asynchronous inputs
    output wire [W-1:0] q  // synchronised outputs
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            // the first stage feeds only the second
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= d[i];
                    s2_q <= s1_q;
                end
            end
            assign q[i] = s2_q;
        end
    endgenerate
endmodule

// ===== verilog/qci_quad.v
`timescale 1ns/10ps
// x4 quadrature decoder, sampled on the prescaled tick
module qci_quad (
    input wire clk,     // system clock
    input wire arst_n,  // async reset, active low
    input wire tick,    // prescaled sample enable
    input wire a,       // processed phase a
    input wire b,       // processed phase b
    output wire step,   // one legal gray step this tick
    output wire down,   // step direction is negative
    output wire a_rise  // phase a rising edge this tick
);
    reg a_q;
    reg b_q;

    // sampling only on the tick is why the tick must outpace the encoder
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else if (tick) begin
            a_q <= a;
            b_q <= b;
        end
    end

    // a double change is a lost edge and is dropped, not guessed
    assign step = tick & ((a ^ a_q) ^ (b ^ b_q));
    assign down = a_q ^ b;
    assign a_rise = tick & a & ~a_q;
endmodule

// ===== verilog/qci_top.v
`timescale 1ns/10ps
`include "qci_regs.vh"
// How it works
// (R01) run enable set runs counters; clear stops them, registers stay accessible
// (R02) idle-halt bit set stops counting while the processor idles
// (R03) init mode 000 ignores index; 001 clears position on every index
// (R04) init mode 010 loads init value on the next index only
// (R05) mode 011 loads on first index after home; 100 on the second
// (R06) mode 101 clears position when it equals the upper compare
// (R07) mode 110 is modulo counting between compares; 111 is reserved
// (R08) phase b match level picks the b level required for index match
// (R09) phase a match level picks the a level required for index match
// (R10) count source 10 or 11 runs timers and ignores init mode
// (R11) in quadrature mode a phase-matched index resets the position
// (R12) match compares phases after swap and inversion
// (R13) software keeps the count clock at least twice the encoder rate
// (R14) 32-bit position, index and timer counters, 16-bit velocity
// (R15) shared init/capture/upper compare register plus lower compare
// (R16) control bits 14 and 7 read zero and ignore writes
// (R17) count source: quadrature, clock with dir, clock, internal timer
// (R18) prescale divides the count clock by two to the field value
// (R19) swap exchanges phases; each invert bit inverts its phase
// (R20) direction invert makes counters count down unless externally set
// (R21) while disabled counters hold and no event alters position
module qci_top (
    input wire clk,                 // 125 MHz system clock
    input wire arst_n,              // async reset, active low
    input wire [5:0] avs_address,   // byte address
    input wire avs_read,            // read request
    input wire avs_write,           // write request
    input wire [3:0] avs_byteenable, // byte lanes
    input wire [31:0] avs_writedata, // write data
    output reg [31:0] avs_readdata, // read data
    output reg avs_waitrequest,     // stall, high when idle
    input wire phase_a_input,       // encoder phase a pin
    input wire phase_b_input,       // encoder phase b pin
    input wire index_input,         // encoder index pin
    input wire home_input,          // home switch pin
    input wire cpu_idle             // processor idle, same clock
);
    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    reg [15:0] encoder_control_q;
    reg [`QCI_IO_WBITS-1:0] io_ctrl_q;
    reg [2:0] stat_q;
    reg [31:0] pos_q;
    reg [31:0] idx_cnt_q;
    reg [31:0] timer_q;
    reg [15:0] vel_q;
    reg [31:0] cmp_hi_q;
    reg [31:0] cmp_lo_q;
    reg [`QCI_DIV_W-1:0] div_q;
    reg idx_lvl_q;
    reg home_lvl_q;
    reg [3:0] hstate_q;
    reg [31:0] pos_d;
    reg [3:0] hstate_d;
    reg load_evt;
    reg [31:0] rd_mux;
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_NEXT = 4'b0010;
    localparam [3:0] S_HOME = 4'b0100;
    localparam [3:0] S_SKIP = 4'b1000;
    wire [3:0] pins_s;
    wire step;
    wire dec_down;
    wire a_rise;
    // ------------------------------------------------------------
    // pin synchronisers and decoder
    // ------------------------------------------------------------
    qci_sync #(.W(4)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({home_input, index_input, phase_b_input, phase_a_input}),
        .q(pins_s)
    );

    // swap first, then invert; decoder and match see the same phases
    wire swap = io_ctrl_q[`QCI_IO_SWAP];
    wire pa = (swap ? pins_s[1] : pins_s[0]) ^ io_ctrl_q[`QCI_IO_AINV]; // R19 R12
    wire pb = (swap ? pins_s[0] : pins_s[1]) ^ io_ctrl_q[`QCI_IO_BINV]; // R19 R12
    wire pidx = pins_s[2] ^ io_ctrl_q[`QCI_IO_IINV];
    wire phome = pins_s[3] ^ io_ctrl_q[`QCI_IO_HINV];

    wire [2:0] pim = encoder_control_q[`QCI_CTRL_PIM_HI:`QCI_CTRL_PIM_LO];
    wire [1:0] count_source_mode = encoder_control_q[`QCI_CTRL_CCM_HI:`QCI_CTRL_CCM_LO];
    wire [2:0] div_sel = encoder_control_q[`QCI_CTRL_DIV_HI:`QCI_CTRL_DIV_LO];
    wire dinv = encoder_control_q[`QCI_CTRL_DINV];
    wire timer_mode = count_source_mode[1]; // R10
    wire run = encoder_control_q[`QCI_CTRL_EN] &
        ~(encoder_control_q[`QCI_CTRL_IDLE] & cpu_idle); // R01 R02 R21

    // ------------------------------------------------------------
    // prescale divider: tick every 2^div_sel clocks
    // ------------------------------------------------------------
    wire [`QCI_DIV_W-1:0] div_mask = ~({`QCI_DIV_W{1'b1}} << div_sel);
    wire tick = ((div_q & div_mask) == div_mask); // R18

    qci_quad u_quad (
        .clk(clk),
        .arst_n(arst_n),
        .tick(tick),
        .a(pa),
        .b(pb),
        .step(step),
        .down(dec_down),
        .a_rise(a_rise)
    );

    // ------------------------------------------------------------
    // count source selection
    // ------------------------------------------------------------
    // gating uses the index level so a gated timer needs no extra pin
    wire gate_ok = ~encoder_control_q[`QCI_CTRL_GATE] | pidx;
    reg cnt_step;
    reg cnt_down;
    always @* begin
        cnt_step = 1'b0;
        cnt_down = dinv;
        case (count_source_mode) // R17
            `QCI_CCM_QUAD: begin
                cnt_step = step;
                cnt_down = dec_down ^ dinv; // R20
            end
            `QCI_CCM_EXTDIR: begin
                cnt_step = a_rise;
                cnt_down = pb ^ dinv; // R20
            end
            `QCI_CCM_EXTCLK: begin
                cnt_step = a_rise & gate_ok;
            end
            default: begin
                cnt_step = tick & gate_ok;
            end
        endcase
    end
    wire do_step = run & cnt_step; // R01 R21

    // ------------------------------------------------------------
    // index and home events
    // ------------------------------------------------------------
    wire phase_match = (pa == encoder_control_q[`QCI_CTRL_IMVA]) & // R09
        (pb == encoder_control_q[`QCI_CTRL_IMVB]); // R08
    wire idx_rise = pidx & ~idx_lvl_q;
    // in quadrature mode an index only counts on the matched phase state
    wire idx_hit = run & idx_rise &
        ((count_source_mode != `QCI_CCM_QUAD) | phase_match); // R11 R12 R21
    wire home_evt = run & phome & ~home_lvl_q; // R21
    wire init_on = ~timer_mode; // R10

    // ------------------------------------------------------------
    // avalon slave: accept, then one cycle with waitrequest low
    // ------------------------------------------------------------
    wire req = avs_read | avs_write;
    wire rd_cap = avs_read & avs_waitrequest;
    wire wr_go = avs_write & ~avs_waitrequest;
    wire [5:0] wa = {avs_address[5:2], 2'b00};
    wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wmask = avs_writedata & bmask;
    wire wr_ctrl = wr_go & (wa == `QCI_OFF_CTRL);
    wire wr_pos = wr_go & (wa == `QCI_OFF_POS);
    wire wr_cmphi = wr_go & (wa == `QCI_OFF_CMPHI);
    wire rd_vel = rd_cap & (wa == `QCI_OFF_VEL);
    wire [15:0] ctrl_new = ((encoder_control_q & ~bmask[15:0]) |
        wmask[15:0]) & `QCI_CTRL_WMASK; // R16
    wire [2:0] new_pim = ctrl_new[`QCI_CTRL_PIM_HI:`QCI_CTRL_PIM_LO];

    // ------------------------------------------------------------
    // homing sequencer
    // ------------------------------------------------------------
    always @* begin
        hstate_d = hstate_q;
        load_evt = 1'b0;
        case (hstate_q)
            S_IDLE: begin
                if (home_evt & init_on &
                    ((pim == `QCI_PIM_HOME1) | (pim == `QCI_PIM_HOME2))) begin
                    hstate_d = S_HOME; // R05
                end
            end
            S_NEXT, S_SKIP: begin
                if (idx_hit & init_on) begin
                    load_evt = 1'b1; // R04 R05
                    hstate_d = S_IDLE;
                end
            end
            S_HOME: begin
                if (idx_hit & init_on) begin
                    if (pim == `QCI_PIM_HOME1) begin
                        load_evt = 1'b1; // R05
                        hstate_d = S_IDLE;
                    end else begin
                        hstate_d = S_SKIP; // R05
                    end
                end
            end
            default: begin
                hstate_d = S_IDLE;
            end
        endcase
        // a control write restarts the sequence in the new mode
        if (wr_ctrl) begin
            hstate_d = (new_pim == `QCI_PIM_NEXT) ? S_NEXT : S_IDLE; // R04
        end
    end

    // ------------------------------------------------------------
    // position next value: software > init event > compare > step
    // ------------------------------------------------------------
    wire [31:0] pos_inc = cnt_down ? pos_q - 32'h0000_0001 :
        pos_q + 32'h0000_0001;
    always @* begin
        pos_d = pos_q;
        if (do_step) begin
            pos_d = pos_inc;
            if (init_on & (pim == `QCI_PIM_MOD)) begin
                if (~cnt_down & (pos_q == cmp_hi_q)) begin
                    pos_d = cmp_lo_q; // R07
                end else if (cnt_down & (pos_q == cmp_lo_q)) begin
                    pos_d = cmp_hi_q; // R07
                end
            end
        end
        if (run & init_on & (pim == `QCI_PIM_CMP) & (pos_q == cmp_hi_q)) begin
            pos_d = 32'h0000_0000; // R06
        end
        if (idx_hit & init_on & (pim == `QCI_PIM_CLR)) begin
            pos_d = 32'h0000_0000; // R03 R11
        end
        if (load_evt) begin
            pos_d = cmp_hi_q; // R04 R05 R15
        end
        if (wr_pos) begin
            pos_d = (pos_q & ~bmask) | wmask;
        end
    end

    // ------------------------------------------------------------
    // register file and counters
    // ------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            encoder_control_q <= `QCI_CTRL_RST;
            io_ctrl_q <= `QCI_IO_RST;
            stat_q <= 3'h0;
            pos_q <= 32'h0000_0000;
            idx_cnt_q <= 32'h0000_0000;
            timer_q <= 32'h0000_0000;
            vel_q <= 16'h0000;
            cmp_hi_q <= 32'h0000_0000;
            cmp_lo_q <= 32'h0000_0000;
            hstate_q <= S_IDLE;
            div_q <= {`QCI_DIV_W{1'b0}};
            idx_lvl_q <= 1'b0;
            home_lvl_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            hstate_q <= hstate_d;
            pos_q <= pos_d; // R14
            idx_lvl_q <= pidx;
            home_lvl_q <= phome;
            if (run) begin
                div_q <= div_q + 1'b1; // R18
            end
            if (wr_ctrl) begin
                encoder_control_q <= ctrl_new; // R16
            end
            if (wr_go & (wa == `QCI_OFF_IOCTL) & avs_byteenable[0]) begin
                io_ctrl_q <= avs_writedata[`QCI_IO_WBITS-1:0];
            end
            // sticky flags: a new event beats a clear in the same cycle
            stat_q <= (stat_q & ~((wr_go & (wa == `QCI_OFF_STAT) &
                avs_byteenable[0]) ? avs_writedata[2:0] : 3'h0)) |
                {load_evt, home_evt, idx_hit};
            if (wr_go & (wa == `QCI_OFF_IDXCNT)) begin
                idx_cnt_q <= (idx_cnt_q & ~bmask) | wmask;
            end else if (idx_hit) begin
                idx_cnt_q <= cnt_down ? idx_cnt_q - 32'h0000_0001 :
                    idx_cnt_q + 32'h0000_0001; // R14 R20
            end
            // interval timer measures ticks between count steps
            if (wr_go & (wa == `QCI_OFF_TIMER)) begin
                timer_q <= (timer_q & ~bmask) | wmask;
            end else if (do_step & ~timer_mode) begin
                timer_q <= 32'h0000_0000;
            end else if (run & tick) begin
                timer_q <= timer_q + 32'h0000_0001; // R14
            end
            // velocity clears on read; a step in that cycle is kept
            if (do_step) begin
                vel_q <= (rd_vel ? 16'h0000 : vel_q) +
                    (cnt_down ? 16'hFFFF : 16'h0001); // R14
            end else if (rd_vel) begin
                vel_q <= 16'h0000;
            end else if (wr_go & (wa == `QCI_OFF_VEL)) begin
                vel_q <= (vel_q & ~bmask[15:0]) | wmask[15:0];
            end
            if (wr_cmphi) begin
                cmp_hi_q <= (cmp_hi_q & ~bmask) | wmask; // R15
            end else if (idx_hit & io_ctrl_q[`QCI_IO_CAPEN]) begin
                cmp_hi_q <= pos_q; // R15
            end
            if (wr_go & (wa == `QCI_OFF_CMPLO)) begin
                cmp_lo_q <= (cmp_lo_q & ~bmask) | wmask; // R15
            end
            // waitrequest rests high, so every access takes two cycles
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (rd_cap) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // read mux; unmapped reads return zero
    // ------------------------------------------------------------
    always @* begin
        case (wa)
            `QCI_OFF_CTRL: rd_mux = {16'h0000, encoder_control_q}; // R16
            `QCI_OFF_IOCTL: rd_mux = {20'h00000, phome, pidx, pb, pa,
                2'b00, io_ctrl_q};
            `QCI_OFF_STAT: rd_mux = {29'h0000_0000, stat_q};
            `QCI_OFF_POS: rd_mux = pos_q;
            `QCI_OFF_IDXCNT: rd_mux = idx_cnt_q;
            `QCI_OFF_TIMER: rd_mux = timer_q;
            `QCI_OFF_VEL: rd_mux = {16'h0000, vel_q};
            `QCI_OFF_CMPHI: rd_mux = cmp_hi_q;
            `QCI_OFF_CMPLO: rd_mux = cmp_lo_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
endmodule

// ===== verification/qci_checker.sv
`timescale 1ns/10ps
`include "qci_regs.vh"
module qci_checker (
    input wire clk, // system clock
    input wire arst_n, // reset, active low
    input wire [5:0] avs_address, // byte address
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire [3:0] avs_byteenable, // byte lanes
    input wire [31:0] avs_writedata, // write data
    input wire [31:0] avs_readdata, // read data
    input wire avs_waitrequest // stall
);
    wire req = avs_read | avs_write;
    wire rd_take = avs_read & avs_waitrequest;
    wire wr_done = avs_write & ~avs_waitrequest;
    wire [3:0] wa = avs_address[5:2];
    wire [15:0] lane = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0] cm = lane & `QCI_CTRL_WMASK;
    reg [15:0] ctl_q;
    reg [5:0] io_q;

    // shadow of the writable bits, so readback is judged lane by lane
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= 16'h0000;
            io_q <= 6'h00;
        end else if (wr_done && wa == 4'h0) begin
            ctl_q <= (ctl_q & ~cm) | (avs_writedata[15:0] & cm);
        end else if (wr_done && wa == 4'h1 && avs_byteenable[0]) begin
            io_q <= avs_writedata[5:0];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ----------------------------------------------------------------
    // bus timing and register contents
    // ----------------------------------------------------------------
    chk_ack_next: assert property (
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in the next cycle");
    chk_ack_single: assert property (
        $fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    chk_no_idle_ack: assert property (
        !req |=> avs_waitrequest)
        else $error("answer without a request");
    chk_data_hold: assert property (
        !rd_take |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    chk_ctrl_readback: assert property (
        rd_take && wa == 4'h0 |=> avs_readdata == {16'h0000, ctl_q})
        else $error("control readback wrong");
    chk_unmapped_zero: assert property (
        rd_take && wa > 4'h8 |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_vel_width: assert property (
        rd_take && wa == 4'h6 |=> avs_readdata[31:16] == 16'h0000)
        else $error("velocity wider than 16 bits");
    chk_io_readback: assert property (
        rd_take && wa == 4'h1 |=>
        avs_readdata[5:0] == io_q && avs_readdata[31:12] == 20'h00000)
        else $error("io control readback wrong");

    cov_ctrl_read: cover property (rd_take && wa == 4'h0);
    cov_write: cover property (wr_done);
    cov_pos_read: cover property (rd_take && wa == 4'h3);
endmodule

bind qci_top qci_checker i_qci_checker (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

// ===== verification/qci_enc_model.sv
`timescale 1ns/10ps
module qci_enc_model (
    input wire clk, // system clock
    input wire arst_n, // reset, active low
    input wire step_req, // take one step this cycle
    input wire dir, // 1 steps backwards
    input wire idx_on, // hold index pin high
    output wire phase_a, // phase a pin
    output wire phase_b, // phase b pin
    output wire index // index pin
);
    reg [1:0] ang_q;

    // quarter-cycle angle; only one phase moves per step
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ang_q <= 2'h0;
        else if (step_req)
            ang_q <= dir ? ang_q - 2'h1 : ang_q + 2'h1;
    end

    // gray order b,a: 00, 01, 11, 10 forward, so a leads b
    assign phase_a = ang_q[1] ^ ang_q[0];
    assign phase_b = ang_q[1];
    assign index = idx_on;
endmodule

// ===== verification/qci_tb.sv
`timescale 1ns/10ps
`include "qci_regs.vh"
module testbench;
    localparam [5:0] o_ctl = `QCI_OFF_CTRL;
    localparam [5:0] o_io = `QCI_OFF_IOCTL;
    localparam [5:0] o_pos = `QCI_OFF_POS;
    localparam [5:0] o_hi = `QCI_OFF_CMPHI;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [5:0] adr = 6'h00;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wd = 32'h0;
    reg stp = 1'b0;
    reg dir = 1'b0;
    reg idx = 1'b0;
    reg hom = 1'b0;
    reg idle = 1'b0;
    reg [31:0] v;
    wire [31:0] rdat;
    wire wrq;
    wire pa, pb, pi;
    integer err_count = 0;
    integer check_count = 0;
    integer cyc = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    qci_top i_qci_top (
        .clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_byteenable(4'hF), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wrq), .phase_a_input(pa),
        .phase_b_input(pb), .index_input(pi), .home_input(hom),
        .cpu_idle(idle)
    );
    qci_enc_model i_qci_enc_model (
        .clk(clk), .arst_n(arst_n), .step_req(stp), .dir(dir),
        .idx_on(idx), .phase_a(pa), .phase_b(pb), .index(pi)
    );

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // hang guard; the run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // one access; held until waitrequest is sampled low
    task bus(input we, input [5:0] a, input [31:0] d);
        begin
            adr <= a;
            wd <= d;
            rd <= !we;
            wr <= we;
            @(posedge clk);
            while (wrq !== 1'b0)
                @(posedge clk);
            v = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask

    task w(input [5:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rc(input [5:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk(v, e);
        end
    endtask

    // 0 step up, 1 step down, 2 index pulse, 3 home pulse; pins are
    // spaced well beyond sync delay plus two count ticks
    task act(input [1:0] k);
        begin
            dir <= k[0];
            stp <= !k[1];
            idx <= k == 2'h2;
            hom <= k == 2'h3;
            @(posedge clk);
            stp <= 1'b0;
            repeat (8) @(posedge clk);
            idx <= 1'b0;
            hom <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        begin
            rc(o_ctl, 32'h0);
            rc(o_io, 32'h0);
            w(o_ctl, 32'hFFFFFFFF);
            rc(o_ctl, 32'hBF7F);
            w(o_ctl, 32'h0);
            w(6'h24, 32'hFFFFFFFF);
            rc(6'h24, 32'h0);
        end
    endtask

    // enable, hold, direction and idle halt; angle ends back at zero
    task t_run;
        begin
            w(o_pos, 32'h0);
            w(o_ctl, 32'h8000);
            repeat (3) act(2'h0);
            rc(o_pos, 32'h3);
            w(o_ctl, 32'h0);
            repeat (4) act(2'h0);
            rc(o_pos, 32'h3);
            w(o_hi, 32'h1234);
            rc(o_hi, 32'h1234);
            w(o_ctl, 32'h8008);
            act(2'h0);
            rc(o_pos, 32'h2);
            w(o_ctl, 32'hA000);
            idle <= 1'b1;
            act(2'h0);
            act(2'h1);
            rc(o_pos, 32'h2);
            idle <= 1'b0;
            act(2'h1);
            rc(o_pos, 32'h1);
            act(2'h0);
            rc(`QCI_OFF_VEL, 32'h2);
        end
    endtask

    // one index pulse with both phases low at the pins
    task run_idx(input [2:0] pm, input [1:0] mv, input [1:0] cm,
        input [5:0] io, input [31:0] e);
        begin
            w(o_hi, 32'h77);
            w(o_io, {26'h0, io});
            w(o_ctl, {16'h0, 3'h4, pm, mv, 6'h00, cm});
            w(o_pos, 32'h5);
            act(2'h2);
            rc(o_pos, e);
        end
    endtask

    task t_index;
        begin
            run_idx(3'h0, 2'h0, 2'h0, 6'h00, 32'h5);
            run_idx(3'h1, 2'h0, 2'h0, 6'h00, 32'h0);
            run_idx(3'h1, 2'h2, 2'h0, 6'h00, 32'h5);
            run_idx(3'h1, 2'h1, 2'h0, 6'h00, 32'h5);
            run_idx(3'h1, 2'h3, 2'h0, 6'h06, 32'h0);
            rc(o_io, 32'h306);
            run_idx(3'h1, 2'h0, 2'h2, 6'h00, 32'h5);
            run_idx(3'h3, 2'h0, 2'h0, 6'h00, 32'h5);
            run_idx(3'h2, 2'h0, 2'h0, 6'h00, 32'h77);
            w(o_pos, 32'h5);
            act(2'h2);
            rc(o_pos, 32'h5);
        end
    endtask

    task t_home;
        begin
            w(o_ctl, 32'h8C00);
            w(o_pos, 32'h5);
            act(2'h3);
            act(2'h2);
            rc(o_pos, 32'h77);
            w(o_ctl, 32'h9000);
            w(o_pos, 32'h5);
            act(2'h3);
            act(2'h2);
            rc(o_pos, 32'h5);
            act(2'h2);
            rc(o_pos, 32'h77);
        end
    endtask

    task t_cmp;
        begin
            w(o_hi, 32'h9);
            w(o_ctl, 32'h9400);
            w(o_pos, 32'h9);
            rc(o_pos, 32'h0);
            w(o_hi, 32'h4);
            w(`QCI_OFF_CMPLO, 32'h2);
            w(o_ctl, 32'h9800);
            w(o_pos, 32'h4);
            act(2'h0);
            rc(o_pos, 32'h2);
            act(2'h1);
            rc(o_pos, 32'h4);
        end
    endtask

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_run;
        t_index;
        t_home;
        t_cmp;
        end_sim;
    end
endmodule
